// File: design/sfp_pkg.sv
// Constants for the sector FIFO pointer block.
// Assumes a single clock domain and an 8-bit microcontroller data space.
package sfp_pkg;
    // Pointer geometry
    localparam int PTR_W = 14;
    localparam int LOW_W = 8;
    localparam int HIGH_W = 6;
    localparam logic [13:0] PTR_RESET = 14'h0000;
    localparam logic [13:0] PTR_ONE = 14'h0001;
    localparam logic [13:0] PTR_LAST = 14'h3fff;
    // Register offsets in the microcontroller data space
    localparam logic [15:0] CONF_WR_LOW_OFS = 16'hf0ed;
    localparam logic [15:0] CONF_WR_HIGH_OFS = 16'hf0ee;
    localparam logic [15:0] WORK_RD_LOW_OFS = 16'hf0ef;
    localparam logic [15:0] WORK_RD_HIGH_OFS = 16'hf0f0;
    localparam logic [15:0] CONF_RD_LOW_OFS = 16'hf0f1;
    localparam logic [15:0] CONF_RD_HIGH_OFS = 16'hf0f2;
    // Read data for reserved bits and unmapped offsets
    localparam logic [7:0] READ_ZERO = 8'h00;
    localparam logic [1:0] RSV_ZERO = 2'h0;
endpackage

// File: design/sfp_ptr_if.sv
// Pointer values handed from the pointer core to the register read port.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface sfp_ptr_if;
    logic [13:0] wr_bk;
    logic [13:0] rd_work;
    logic [13:0] rd_bk;
    modport core (output wr_bk, output rd_work, output rd_bk);
    modport regs (input wr_bk, input rd_work, input rd_bk);
endinterface

// File: design/sfp_reg_read.sv
// Read-only register port for the pointer bytes.
// Assumes one read strobe per access on the same clock as the pointers.
`timescale 1ns/1ps
module sfp_reg_read
    import sfp_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [15:0] xdata_addr,
    input wire logic xdata_read,
    sfp_ptr_if.regs ptrs,
    output logic [7:0] xdata_rdata
);
    logic [7:0] next_xdata_rdata;

    // ------------------------------------------------------------
    // Byte select
    // ------------------------------------------------------------
    // Data holds between reads so a slow reader sees a stable byte
    always_comb begin
        next_xdata_rdata = xdata_rdata;
        if (xdata_read) begin
            case (xdata_addr)
                CONF_WR_LOW_OFS: next_xdata_rdata = ptrs.wr_bk[LOW_W-1:0];
                CONF_WR_HIGH_OFS: next_xdata_rdata = {RSV_ZERO, ptrs.wr_bk[PTR_W-1:LOW_W]};
                WORK_RD_LOW_OFS: next_xdata_rdata = ptrs.rd_work[LOW_W-1:0];
                WORK_RD_HIGH_OFS: next_xdata_rdata = {RSV_ZERO, ptrs.rd_work[PTR_W-1:LOW_W]};
                CONF_RD_LOW_OFS: next_xdata_rdata = ptrs.rd_bk[LOW_W-1:0];
                CONF_RD_HIGH_OFS: next_xdata_rdata = {RSV_ZERO, ptrs.rd_bk[PTR_W-1:LOW_W]};
                default: next_xdata_rdata = READ_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            xdata_rdata <= READ_ZERO;
        end else begin
            xdata_rdata <= next_xdata_rdata;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    high_rsv_a: assert property (@(posedge clk) disable iff (!reset_n)
        (xdata_read && (xdata_addr == WORK_RD_HIGH_OFS || xdata_addr == CONF_WR_HIGH_OFS
        || xdata_addr == CONF_RD_HIGH_OFS)) |=> xdata_rdata[7:6] == RSV_ZERO)
        else $error("reserved pointer bits read as one");
    low_byte_a: assert property (@(posedge clk) disable iff (!reset_n)
        (xdata_read && xdata_addr == WORK_RD_LOW_OFS) |=>
        xdata_rdata == $past(ptrs.rd_work[7:0]))
        else $error("read pointer low byte mismatch");
endmodule

// File: design/sfp_top.sv
// Sector FIFO pointer core: working and confirmed write and read pointers.
// Assumes the fill, USB and ATA engines drive one-cycle strobes on clk.
//
// Function
// - Pointers are 14 bits; all but the working write pointer read as low byte and 6-bit high byte, read-only
// - On confirm, working write pointer is copied into confirmed write pointer
// - Readers never pass the confirmed write pointer; unconfirmed data stays hidden
// - Working read pointer is the address of every FIFO read
// - USB ACK timeout reloads working read pointer from confirmed read pointer
// - ATA-side reads are never rewound
// - ATA read increments read pointer and copies new value into confirmed pointer
// - Reset clears working read, confirmed read and confirmed write pointers
// - CRC abort restores working write pointer from confirmed write pointer
// - USB ACK copies working read pointer into confirmed read pointer
`timescale 1ns/1ps
module sfp_top
    import sfp_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic fill_strobe,
    input wire logic fill_confirm,
    input wire logic fill_abort,
    input wire logic usb_read_strobe,
    input wire logic usb_ack,
    input wire logic usb_ack_timeout,
    input wire logic ata_read_strobe,
    input wire logic [15:0] xdata_addr,
    input wire logic xdata_read,
    output logic [7:0] xdata_rdata,
    output logic [13:0] write_address,
    output logic [13:0] read_address,
    output logic read_available
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [13:0] working_write_pointer;
    logic [13:0] confirmed_write_pointer;
    logic [13:0] working_read_pointer;
    logic [13:0] confirmed_read_pointer;
    logic [13:0] next_working_write_pointer;
    logic [13:0] next_confirmed_write_pointer;
    logic [13:0] next_working_read_pointer;
    logic [13:0] next_confirmed_read_pointer;
    logic next_read_available;
    logic data_ready;
    logic ata_take;
    logic usb_take;

    // Wraps modulo the 14-bit FIFO space
    function automatic logic [13:0] ptr_inc(input logic [13:0] p);
        ptr_inc = p + PTR_ONE;
    endfunction

    // ------------------------------------------------------------
    // Read acceptance
    // ------------------------------------------------------------
    // Data up to the confirmed write pointer only; ATA wins a clash
    assign data_ready = (working_read_pointer != confirmed_write_pointer);
    assign ata_take = ata_read_strobe && data_ready;
    assign usb_take = usb_read_strobe && data_ready && !ata_read_strobe;

    // ------------------------------------------------------------
    // Write pointer pair
    // ------------------------------------------------------------
    // Abort beats both a write and a confirm in the same cycle
    always_comb begin
        next_working_write_pointer = working_write_pointer;
        next_confirmed_write_pointer = confirmed_write_pointer;
        if (fill_abort) begin
            next_working_write_pointer = confirmed_write_pointer;
        end else begin
            if (fill_confirm) begin
                next_confirmed_write_pointer = working_write_pointer;
            end
            if (fill_strobe) begin
                next_working_write_pointer = ptr_inc(working_write_pointer);
            end
        end
    end

    // ------------------------------------------------------------
    // Read pointer pair
    // ------------------------------------------------------------
    // A rewind drops any read strobe in the same cycle
    always_comb begin
        next_working_read_pointer = working_read_pointer;
        next_confirmed_read_pointer = confirmed_read_pointer;
        if (usb_ack_timeout) begin
            next_working_read_pointer = confirmed_read_pointer;
        end else if (ata_take) begin
            // No backup copy survives an ATA read, so nothing can rewind it
            next_working_read_pointer = ptr_inc(working_read_pointer);
            next_confirmed_read_pointer = ptr_inc(working_read_pointer);
        end else begin
            if (usb_ack) begin
                next_confirmed_read_pointer = working_read_pointer;
            end
            if (usb_take) begin
                next_working_read_pointer = ptr_inc(working_read_pointer);
            end
        end
        next_read_available = (next_working_read_pointer != next_confirmed_write_pointer);
    end

    // Working write pointer has no reset value of its own documented; zero is used
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            working_write_pointer <= PTR_RESET;
            confirmed_write_pointer <= PTR_RESET;
            working_read_pointer <= PTR_RESET;
            confirmed_read_pointer <= PTR_RESET;
            read_available <= 1'b0;
        end else begin
            working_write_pointer <= next_working_write_pointer;
            confirmed_write_pointer <= next_confirmed_write_pointer;
            working_read_pointer <= next_working_read_pointer;
            confirmed_read_pointer <= next_confirmed_read_pointer;
            read_available <= next_read_available;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Addresses are the pointer flops themselves
    assign write_address = working_write_pointer;
    assign read_address = working_read_pointer;

    sfp_ptr_if ptr_bus();
    assign ptr_bus.wr_bk = confirmed_write_pointer;
    assign ptr_bus.rd_work = working_read_pointer;
    assign ptr_bus.rd_bk = confirmed_read_pointer;

    sfp_reg_read u_reg_read (
        .clk(clk),
        .reset_n(reset_n),
        .xdata_addr(xdata_addr),
        .xdata_read(xdata_read),
        .ptrs(ptr_bus.regs),
        .xdata_rdata(xdata_rdata)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    confirm_copy_a: assert property (
        (fill_confirm && !fill_abort) |=>
        confirmed_write_pointer == $past(working_write_pointer))
        else $error("confirm did not copy write pointer");

    read_bound_a: assert property (
        (working_read_pointer == confirmed_write_pointer && !usb_ack_timeout) |=>
        working_read_pointer == $past(working_read_pointer))
        else $error("read passed confirmed write pointer");

    read_step_a: assert property (
        (usb_take && !usb_ack_timeout) |=> read_address == ptr_inc($past(read_address)))
        else $error("read address did not step");

    rewind_a: assert property (
        usb_ack_timeout |=> working_read_pointer == $past(confirmed_read_pointer))
        else $error("timeout did not rewind");

    ata_commit_a: assert property (
        (ata_take && !usb_ack_timeout) |=>
        (confirmed_read_pointer == working_read_pointer &&
        working_read_pointer == ptr_inc($past(working_read_pointer))))
        else $error("ata read not committed");

    ata_norewind_a: assert property (
        (ata_take && !usb_ack_timeout) ##1 usb_ack_timeout |=>
        working_read_pointer == $past(working_read_pointer))
        else $error("ata data was rewound");

    reset_clear_a: assert property (@(posedge clk) disable iff (1'b0)
        !reset_n |=> (working_read_pointer == PTR_RESET &&
        confirmed_read_pointer == PTR_RESET && confirmed_write_pointer == PTR_RESET))
        else $error("pointers not cleared by reset");

    abort_restore_a: assert property (
        fill_abort |=> write_address == $past(confirmed_write_pointer))
        else $error("abort did not restore write pointer");

    ack_copy_a: assert property (
        (usb_ack && !usb_ack_timeout && !ata_take) |=>
        confirmed_read_pointer == $past(working_read_pointer))
        else $error("ack did not confirm read pointer");

    wrap_a: assert property (
        (fill_strobe && !fill_abort && working_write_pointer == PTR_LAST) |=>
        working_write_pointer == PTR_RESET)
        else $error("write pointer did not wrap");

    avail_a: assert property (
        read_available == (working_read_pointer != confirmed_write_pointer))
        else $error("availability flag out of step");

    abort_first_a: assert property (
        (fill_abort && fill_confirm) |=>
        confirmed_write_pointer == $past(confirmed_write_pointer))
        else $error("confirm taken despite abort");

    backup_hold_a: assert property (
        !fill_confirm |=>
        confirmed_write_pointer == $past(confirmed_write_pointer))
        else $error("confirmed write pointer moved without confirm");

    rewind_keep_a: assert property (
        usb_ack_timeout |=>
        confirmed_read_pointer == $past(confirmed_read_pointer))
        else $error("timeout changed confirmed read pointer");

    confirm_then_read_c: cover property (fill_confirm ##[1:8] usb_take);
    abort_c: cover property (fill_strobe ##1 fill_abort);
    rewind_c: cover property (usb_take ##[1:8] usb_ack_timeout);
    ata_read_c: cover property (ata_take ##1 ata_take);
    abort_confirm_c: cover property (fill_abort && fill_confirm);
endmodule

// File: dv/sfp_far_model.sv
// Far-side model: fill engine, USB buffer manager and ATA read side.
// Assumes the caller runs on clk; strobes change only at rising edges.
`timescale 1ns/1ps
module sfp_far_model (
    input wire logic clk,
    output logic [6:0] strobes
);
    // --------------------------------
    // Strobe bursts
    // --------------------------------
    initial begin
        strobes = 7'h00;
    end

    // Holds a strobe set for n back-to-back edges, then drops it
    task automatic pulse(input logic [6:0] m, input int n);
        @(posedge clk);
        strobes <= m;
        repeat (n) @(posedge clk);
        strobes <= 7'h00; // Released on the last taken edge
    endtask

    // Two strobe sets on consecutive edges, for back-to-back event pairs
    task automatic pulse_pair(input logic [6:0] m1, input logic [6:0] m2);
        @(posedge clk);
        strobes <= m1;
        @(posedge clk);
        strobes <= m2;
        @(posedge clk);
        strobes <= 7'h00;
    endtask
endmodule

// File: dv/tb.sv
// Self-checking bench for the sector FIFO pointer block.
// Assumes sfp_pkg and the design files are compiled first.
`timescale 1ns/1ps
module tb import sfp_pkg::*; ;
    localparam logic [6:0] FILL = 7'h40, CONF = 7'h20, ABRT = 7'h10, USBR = 7'h08;
    localparam logic [6:0] ACK = 7'h04, TMO = 7'h02, ATA = 7'h01;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [6:0] strobes;
    logic [15:0] xdata_addr = 16'h0000;
    logic xdata_read = 1'b0;
    logic [7:0] xdata_rdata;
    logic [13:0] write_address;
    logic [13:0] read_address;
    logic read_available;
    int errors = 0;
    int checks_done = 0;
    int cycles = 0;

    // --------------------------------
    // Clock, timeout, instances
    // --------------------------------
    always #4 clk = ~clk;
    // Wrap test alone needs about 16k cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            errors = errors + 1;
            summarize();
        end
    end
    sfp_far_model far (.clk(clk), .strobes(strobes));
    sfp_top dut (.clk(clk), .reset_n(reset_n), .fill_strobe(strobes[6]),
        .fill_confirm(strobes[5]), .fill_abort(strobes[4]), .usb_read_strobe(strobes[3]),
        .usb_ack(strobes[2]), .usb_ack_timeout(strobes[1]), .ata_read_strobe(strobes[0]),
        .xdata_addr(xdata_addr), .xdata_read(xdata_read), .xdata_rdata(xdata_rdata),
        .write_address(write_address), .read_address(read_address),
        .read_available(read_available));

    // --------------------------------
    // Checking and register access
    // --------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("mismatch at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    // One read strobe; data is registered on the taking edge
    task automatic reg_read(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        xdata_read <= 1'b1;
        xdata_addr <= a;
        @(posedge clk);
        xdata_read <= 1'b0;
        #1 d = xdata_rdata;
    endtask

    // Low byte then high byte; reserved top bits must come back zero
    task automatic ptr_read(input logic [15:0] a, output logic [15:0] v);
        logic [7:0] lo;
        logic [7:0] hi;
        reg_read(a, lo);
        reg_read(a + 16'h0001, hi);
        v = {hi, lo};
    endtask

    task automatic check_ptrs(input logic [13:0] wp, input logic [13:0] wbk,
        input logic [13:0] rp, input logic [13:0] rbk);
        logic [15:0] v;
        ptr_read(CONF_WR_LOW_OFS, v);
        check(v, {2'h0, wbk});
        ptr_read(WORK_RD_LOW_OFS, v);
        check(v, {2'h0, rp});
        ptr_read(CONF_RD_LOW_OFS, v);
        check(v, {2'h0, rbk});
        check({2'h0, write_address}, {2'h0, wp});
        check({2'h0, read_address}, {2'h0, rp});
    endtask

    task automatic summarize();
        if (errors == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // --------------------------------
    // Scenarios
    // --------------------------------
    initial begin
        logic [7:0] d;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        check_ptrs(14'h0000, 14'h0000, 14'h0000, 14'h0000);
        reg_read(16'hf0f3, d);
        check({8'h00, d}, 16'h0000);
        far.pulse(FILL, 5);
        far.pulse(ATA, 1);
        check_ptrs(14'h0005, 14'h0000, 14'h0000, 14'h0000);
        check({15'h0000, read_available}, 16'h0000);
        far.pulse(CONF, 1);
        check_ptrs(14'h0005, 14'h0005, 14'h0000, 14'h0000);
        check({15'h0000, read_available}, 16'h0001);
        far.pulse(FILL, 2);
        far.pulse(ABRT, 1);
        check_ptrs(14'h0005, 14'h0005, 14'h0000, 14'h0000);
        far.pulse(USBR, 3);
        check_ptrs(14'h0005, 14'h0005, 14'h0003, 14'h0000);
        far.pulse(ACK, 1);
        far.pulse(USBR, 1);
        check_ptrs(14'h0005, 14'h0005, 14'h0004, 14'h0003);
        // Rewind with a read strobe in the same cycle: restore must win
        far.pulse(TMO | USBR, 1);
        check_ptrs(14'h0005, 14'h0005, 14'h0003, 14'h0003);
        far.pulse(ATA, 1);
        check_ptrs(14'h0005, 14'h0005, 14'h0004, 14'h0004);
        far.pulse(TMO, 1);
        check_ptrs(14'h0005, 14'h0005, 14'h0004, 14'h0004);
        far.pulse(USBR, 5);
        check_ptrs(14'h0005, 14'h0005, 14'h0005, 14'h0004);
        check({15'h0000, read_available}, 16'h0000);
        far.pulse(FILL, 16378);
        far.pulse(CONF, 1);
        check_ptrs(14'h3fff, 14'h3fff, 14'h0005, 14'h0004);
        far.pulse(FILL, 1);
        check_ptrs(14'h0000, 14'h3fff, 14'h0005, 14'h0004);
        // Coincident and back-to-back events
        far.pulse(ATA | USBR, 2);
        check_ptrs(14'h0000, 14'h3fff, 14'h0007, 14'h0007);
        far.pulse_pair(USBR, TMO);
        check_ptrs(14'h0000, 14'h3fff, 14'h0007, 14'h0007);
        far.pulse_pair(ATA, TMO);
        check_ptrs(14'h0000, 14'h3fff, 14'h0008, 14'h0008);
        far.pulse_pair(FILL, ABRT);
        check_ptrs(14'h3fff, 14'h3fff, 14'h0008, 14'h0008);
        far.pulse(CONF | FILL, 1);
        check_ptrs(14'h0000, 14'h3fff, 14'h0008, 14'h0008);
        far.pulse(CONF | ABRT, 1);
        check_ptrs(14'h3fff, 14'h3fff, 14'h0008, 14'h0008);
        far.pulse_pair(CONF, USBR);
        check_ptrs(14'h3fff, 14'h3fff, 14'h0009, 14'h0008);
        far.pulse(ACK | ATA, 1);
        check_ptrs(14'h3fff, 14'h3fff, 14'h000a, 14'h000a);
        far.pulse(USBR, 2);
        far.pulse(TMO | ACK, 1);
        check_ptrs(14'h3fff, 14'h3fff, 14'h000a, 14'h000a);
        // Reset in mid-run must clear every pointer again
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        check_ptrs(14'h0000, 14'h0000, 14'h0000, 14'h0000);
        check({15'h0000, read_available}, 16'h0000);
        summarize();
    end
endmodule
